// file: verif/fcs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model
    import fcs_pkg::*;
#(
    parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value
    parameter logic [7:0] PART  = 8'hc3, // Arbitrary value
    parameter int BUSY_CYC      = 40
)(
    // Clock
    input wire logic              clk,
    // Flash pins
    input wire fcs_pins_s         pins,
    output logic [DATA_W-1:0]     dq_in
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] cmd = CMD_READ;
    logic [7:0] pd = '0;
    logic [ADDR_W-1:0] wa = '0;
    logic we_q = 1'b1;
    logic ers = 1'b0;
    int busy = 0;
    initial begin
        dq_in = '0;
        for (int i = 0; i < (1<<ADDR_W); i++) mem[i] = 8'(i) ^ 8'h5a;
    end
    always @(posedge clk) begin
        we_q <= pins.we_n;
        if (we_q && !pins.we_n) wa <= pins.addr;
        if (busy == 1 && ers) foreach (mem[i]) mem[i] <= ERASED_BYTE;
        if (busy > 0) busy <= busy - 1;
        if (!pins.vpp_hi) cmd <= CMD_READ;
        else if (!we_q && pins.we_n && !pins.ce_n && pins.oe_n && busy == 0) begin
            case (cmd)
                CMD_PROG_A, CMD_PROG_B: begin
                    mem[wa] <= mem[wa] & pins.dq_out;
                    pd <= pins.dq_out;
                    ers <= 1'b0;
                    if (pins.dq_out != CMD_RESET) busy <= BUSY_CYC;
                    cmd <= CMD_READ;
                end
                CMD_ERASE: begin
                    if (pins.dq_out == CMD_ERASE) ers <= 1'b1;
                    if (pins.dq_out == CMD_ERASE) busy <= BUSY_CYC;
                    cmd <= (pins.dq_out == CMD_ERASE) ? CMD_READ : pins.dq_out;
                end
                default: cmd <= pins.dq_out;
            endcase
        end
        if (!pins.ce_n && !pins.oe_n) begin
            if (busy > 0) dq_in <= ers ? 8'h00 : {~pd[7], pd[6:0]};
            else if (cmd == CMD_ID_A || cmd == CMD_ID_B) dq_in <= pins.addr[0] ? PART : MAKER;
            else dq_in <= mem[pins.addr];
        end else dq_in <= ~dq_in;
    end
endmodule : fcs_flash_model
`default_nettype wire

// file: verif/fcs_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_host_checker
    import fcs_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // Request side
    input wire logic              req_valid,
    input wire fcs_req_s          req,
    input wire logic              req_ready,
    input wire logic              done,
    input wire logic              verify_fail,
    input wire logic [DATA_W-1:0] rd_data,
    // Flash pins
    input wire fcs_pins_s         pins,
    input wire logic [DATA_W-1:0] dq_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_pulse;
        !pins.we_n [*6] ##1 pins.we_n;
    endsequence
    property p_vpp; $fell(pins.we_n) |-> pins.vpp_hi; endproperty
    property p_wid; $fell(pins.we_n) |-> s_pulse; endproperty
    property p_wen; !pins.we_n |-> pins.oe_n && !pins.ce_n && pins.dq_oe; endproperty
    property p_adr; !pins.we_n |=> pins.we_n || $stable(pins.addr); endproperty
    property p_dat; $rose(pins.we_n) |-> $stable(pins.dq_out) && !pins.ce_n; endproperty
    property p_bus; !pins.oe_n |-> !pins.dq_oe; endproperty
    property p_take; req_valid && req_ready |=> !req_ready; endproperty
    property p_done; done |=> !done; endproperty
    property p_back; done |-> ##[0:1] req_ready; endproperty
    property p_hold; req_ready && !req_valid |=> $stable(rd_data); endproperty
    a_vpp: assert property (p_vpp) else $error("write with supply low");
    a_wid: assert property (p_wid) else $error("strobe width wrong");
    a_wen: assert property (p_wen) else $error("write pins wrong");
    a_adr: assert property (p_adr) else $error("address moved in pulse");
    a_dat: assert property (p_dat) else $error("data moved at rise");
    a_bus: assert property (p_bus) else $error("bus contention");
    a_take: assert property (p_take) else $error("ready held");
    a_done: assert property (p_done) else $error("done too long");
    a_back: assert property (p_back) else $error("ready late");
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule : fcs_host_checker
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fcs_pkg::*;
;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
    localparam logic [7:0] PART  = 8'hc3; // Arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    fcs_req_s req = '0;
    logic req_ready, done, verify_fail;
    logic [DATA_W-1:0] rd_data, dq_in;
    fcs_pins_s pins;
    logic we_q = 1'b1;
    logic [7:0] wlog [$];
    int error_cnt = 0;
    int n_compared = 0;
    always #5 clk = ~clk;
    fcs_host uut (.clk, .rst_n, .req_valid, .req, .req_ready, .done,
        .verify_fail, .rd_data, .pins, .dq_in);
    fcs_flash_model #(.MAKER(MAKER), .PART(PART)) u_flash (.clk, .pins, .dq_in);
    // Log of data bytes at each strobe rise
    always @(posedge clk) begin
        we_q <= pins.we_n;
        if (!we_q && pins.we_n === 1'b1) wlog.push_back(pins.dq_out);
    end
    function automatic logic [7:0] init_b(logic [ADDR_W-1:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction : init_b
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic results();
        if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic issue(fcs_op_e op, logic [ADDR_W-1:0] a, logic [7:0] d);
        int n;
        wlog.delete();
        for (n = 0; n < 300 && req_ready !== 1'b1; n++) @(negedge clk);
        if (n >= 300) begin
            error_cnt++;
            results();
        end
        @(posedge clk) req_valid <= 1'b1;
        req <= '{op, a, d};
        @(posedge clk) req_valid <= 1'b0;
    endtask : issue
    task automatic do_op(fcs_op_e op, logic [ADDR_W-1:0] a, logic [7:0] d);
        int n;
        issue(op, a, d);
        for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk);
        if (n >= 3000) error_cnt++;
        if (n >= 3000) results();
    endtask : do_op
    task automatic t_read();
        @(negedge clk) check("vpp_hi", 8'h00, 8'(pins.vpp_hi));
        do_op(OP_READ, 17'h00005, 8'h00);
        check("read cmd", CMD_READ, wlog[0]);
        check("rd_data", init_b(17'h00005), rd_data);
        do_op(OP_READ, 17'h1ffff, 8'h00);
        check("rd_data top", init_b(17'h1ffff), rd_data);
    endtask : t_read
    task automatic t_prog();
        do_op(OP_PROGRAM, 17'h00123, 8'h0f);
        check("setup", CMD_PROG_A, wlog[0]);
        check("pdata", 8'h0f, wlog[1]);
        do_op(OP_READ, 17'h00123, 8'h00);
        check("programmed", init_b(17'h00123) & 8'h0f, rd_data);
        check("verify_fail", 8'h00, 8'(verify_fail));
    endtask : t_prog
    task automatic t_id();
        do_op(OP_READ_ID, ID_MAKER_ADDR, 8'h00);
        check("id cmd", CMD_ID_B, wlog[0]);
        check("maker", MAKER, rd_data);
        do_op(OP_READ_ID, ID_PART_ADDR, 8'h00);
        check("part", PART, rd_data);
    endtask : t_id
    task automatic t_abort();
        // Location whose poll bit is already one, so null data completes at once
        do_op(OP_PROGRAM, 17'h00280, CMD_RESET);
        do_op(OP_ABORT, 17'h00000, 8'h00);
        check("abort n", 8'h02, 8'(wlog.size()));
        check("abort 2", CMD_RESET, wlog[1]);
        do_op(OP_READ, 17'h00280, 8'h00);
        check("untouched", init_b(17'h00280), rd_data);
    endtask : t_abort
    task automatic t_erase();
        int n;
        issue(OP_ERASE, 17'h00000, 8'h00);
        for (n = 0; n < 500 && wlog.size() < 2; n++) @(negedge clk);
        if (n >= 500) begin
            error_cnt++;
            results();
        end
        check("erase 1", CMD_ERASE, wlog[0]);
        check("erase 2", CMD_ERASE, wlog[1]);
        // Fixed watch window, well inside the model's busy time
        for (n = 0; n < 30; n++) begin
            @(negedge clk);
            if (done !== 1'b0) break;
        end
        check("done in erase", 8'h00, 8'(done));
        check("erase poll", 8'h00, 8'(rd_data[POLL_BIT]));
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk) check("vpp after rst", 8'h00, 8'(pins.vpp_hi));
        check("ce_n after rst", 8'h01, 8'(pins.ce_n));
        @(posedge clk) rst_n <= 1'b1;
        do_op(OP_READ, 17'h00123, 8'h00);
        check("erased", ERASED_BYTE, rd_data);
        check("verify_fail rst", 8'h00, 8'(verify_fail));
    endtask : t_erase
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_read();
        t_prog();
        t_id();
        t_abort();
        t_erase();
        results();
    end
endmodule : tb_top
bind fcs_host fcs_host_checker u_chk (.clk, .rst_n, .req_valid, .req, .req_ready,
    .done, .verify_fail, .rd_data, .pins, .dq_in);
`default_nettype wire

// file: verilog/fcs_host.sv
// Behaviour
// - Raise the supply, then select each operation by writing a command code.
// - Read: one write of 00h or FFh anywhere, then reads at a location.
// - Erase needs two consecutive writes of 30h; the first only arms.
// - Host reads the array back and checks every byte equals FFh.
// - Program setup is a write of 10h or 50h, programming nothing.
// - 80h or 90h enters identifier mode; address 0 maker, 1 part code.
// - After program setup, reset twice: null data then abort to read.
`timescale 1ns/1ps
`default_nettype none
module fcs_host
    import fcs_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Request side
    input  wire logic              req_valid,
    input  wire fcs_req_s          req,
    output logic                   req_ready,
    output logic                   done,
    output logic                   verify_fail,
    output logic [DATA_W-1:0]      rd_data,
    // Flash pins
    output fcs_pins_s              pins,
    input  wire logic [DATA_W-1:0] dq_in
);

    typedef struct packed {
        fcs_state_e          st;
        fcs_req_s            cur;
        logic [1:0]          step;
        logic [ADDR_W-1:0]   scan;
        logic                scanning;
        logic                vpp_up;
        logic [CNT_W-1:0]    cnt;
        logic                ready;
        logic                done;
        logic                fail;
        logic [DATA_W-1:0]   rdata;
        fcs_pins_s           p;
    } fcs_host_s;

    localparam logic [ADDR_W-1:0] SCAN_LAST = {ADDR_W{1'b1}};
    localparam logic [CNT_W-1:0]  C_SETUP   = CNT_W'(SETUP_CYC);
    localparam logic [CNT_W-1:0]  C_PULSE   = CNT_W'(PULSE_CYC);
    localparam logic [CNT_W-1:0]  C_READ    = CNT_W'(READ_CYC);
    localparam logic [CNT_W-1:0]  C_RAMP    = CNT_W'(RAMP_CYC);

    fcs_host_s s_reg;
    fcs_host_s s_next;

    // Number of write cycles for each operation; all but abort then go on to read
    function automatic logic [1:0] n_writes(input fcs_op_e op);
        unique case (op)
            OP_READ, OP_READ_ID: n_writes = 2'd1;
            default:             n_writes = 2'd2;
        endcase
    endfunction : n_writes

    // Data placed on the bus for write number k
    function automatic logic [DATA_W-1:0] wr_data(input fcs_req_s r, input logic [1:0] k);
        unique case (r.op)
            OP_READ:    wr_data = CMD_READ;
            OP_READ_ID: wr_data = CMD_ID_B;
            OP_ERASE:   wr_data = CMD_ERASE;
            OP_PROGRAM: wr_data = (k == 2'd0) ? CMD_PROG_A : r.data;
            OP_ABORT:   wr_data = CMD_RESET;
            default:    wr_data = CMD_RESET;
        endcase
    endfunction : wr_data

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (s_reg.cnt != '0) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end
        unique case (s_reg.st)
            ST_IDLE: begin
                s_next.ready = 1'b1;
                if (req_valid && s_reg.ready) begin
                    s_next.ready = 1'b0;
                    s_next.cur   = req;
                    s_next.step  = 2'd0;
                    s_next.fail  = 1'b0;
                    s_next.scan  = '0;
                    s_next.scanning = 1'b0;
                    s_next.p.vpp_hi = 1'b1;
                    if (!s_reg.vpp_up) begin
                        s_next.cnt = C_RAMP;
                        s_next.st  = ST_RAMP;
                    end else begin
                        s_next.st = ST_W_SETUP;
                        s_next.cnt = C_SETUP;
                    end
                end
            end
            ST_RAMP: begin
                if (s_reg.cnt == '0) begin
                    s_next.vpp_up = 1'b1;
                    s_next.st  = ST_W_SETUP;
                    s_next.cnt = C_SETUP;
                end
            end
            ST_W_SETUP: begin
                // Address stable before strobe falls; don't-care cycles reuse it
                s_next.p.oe_n   = 1'b1;
                s_next.p.ce_n   = 1'b0;
                s_next.p.addr   = s_reg.cur.addr;
                s_next.p.dq_out = wr_data(s_reg.cur, s_reg.step);
                s_next.p.dq_oe  = 1'b1;
                if (s_reg.cnt == '0) begin
                    s_next.p.we_n = 1'b0;
                    s_next.cnt = C_PULSE;
                    s_next.st  = ST_W_PULSE;
                end
            end
            ST_W_PULSE: begin
                if (s_reg.cnt == '0) begin
                    // Strobe rises first so data latches and operation starts
                    s_next.p.we_n = 1'b1;
                    s_next.cnt = C_SETUP;
                    s_next.st  = ST_W_HOLD;
                end
            end
            ST_W_HOLD: begin
                if (s_reg.cnt == '0) begin
                    s_next.p.ce_n  = 1'b1;
                    s_next.p.dq_oe = 1'b0;
                    s_next.step    = s_reg.step + 2'd1;
                    s_next.cnt     = C_SETUP;
                    if (s_reg.step + 2'd1 < n_writes(s_reg.cur.op)) begin
                        s_next.st = ST_W_SETUP;
                    end else if (s_reg.cur.op == OP_ABORT) begin
                        s_next.st = ST_DONE;
                    end else if (s_reg.cur.op == OP_ERASE) begin
                        s_next.p.addr = '0;
                        s_next.st = ST_R_SETUP;
                    end else begin
                        s_next.st = ST_R_SETUP;
                    end
                end
            end
            ST_R_SETUP: begin
                s_next.p.ce_n = 1'b0;
                s_next.p.oe_n = 1'b0;
                if (s_reg.scanning) begin
                    s_next.p.addr = s_reg.scan;
                end else if (s_reg.cur.op != OP_ERASE) begin
                    s_next.p.addr = s_reg.cur.addr;
                end
                s_next.cnt = C_READ;
                s_next.st  = ST_R_WAIT;
            end
            ST_R_WAIT: begin
                if (s_reg.cnt == '0) begin
                    s_next.rdata  = dq_in;
                    s_next.p.oe_n = 1'b1;
                    s_next.p.ce_n = 1'b1;
                    s_next.cnt    = C_SETUP;
                    s_next.st     = ST_R_DONE;
                end
            end
            ST_R_DONE: begin
                if (s_reg.cnt == '0) begin
                    s_next.st = ST_DONE;
                    if (s_reg.cur.op == OP_ERASE && !s_reg.scanning) begin
                        if (!s_reg.rdata[POLL_BIT]) begin
                            s_next.st = ST_R_SETUP;
                        end else begin
                            s_next.scanning = 1'b1;
                            s_next.scan     = '0;
                            s_next.st       = ST_R_SETUP;
                        end
                    end else if (s_reg.scanning) begin
                        if (s_reg.rdata != ERASED_BYTE) begin
                            s_next.fail = 1'b1;
                        end
                        if (s_reg.scan != SCAN_LAST) begin
                            s_next.scan = s_reg.scan + 1'b1;
                            s_next.st   = ST_R_SETUP;
                        end
                    end else if (s_reg.cur.op == OP_PROGRAM &&
                                 s_reg.rdata[POLL_BIT] != s_reg.cur.data[POLL_BIT]) begin
                        s_next.st = ST_R_SETUP;
                    end
                end
            end
            ST_DONE: begin
                s_next.done = 1'b1;
                s_next.st   = ST_IDLE;
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
            s_reg.p.ce_n <= 1'b1;
            s_reg.p.we_n <= 1'b1;
            s_reg.p.oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign req_ready   = s_reg.ready;
    assign done        = s_reg.done;
    assign verify_fail = s_reg.fail;
    assign rd_data     = s_reg.rdata;
    assign pins        = s_reg.p;

endmodule : fcs_host
`default_nettype wire

// file: verilog/fcs_pkg.sv
package fcs_pkg;

    // Bus geometry
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;

    // Command codes
    localparam logic [7:0] CMD_READ      = 8'h00;
    localparam logic [7:0] CMD_RESET     = 8'hff;
    localparam logic [7:0] CMD_ID_A      = 8'h80;
    localparam logic [7:0] CMD_ID_B      = 8'h90;
    localparam logic [7:0] CMD_ERASE     = 8'h30;
    localparam logic [7:0] CMD_PROG_A    = 8'h10;
    localparam logic [7:0] CMD_PROG_B    = 8'h50;
    localparam logic [7:0] ERASED_BYTE   = 8'hff;
    localparam int         POLL_BIT      = 7;

    // Identifier addresses
    localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 17'h00000;
    localparam logic [ADDR_W-1:0] ID_PART_ADDR  = 17'h00001;

    // Bus timing in cycles of the 100 MHz clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS      = 20;
    localparam int PULSE_NS      = 50;
    localparam int READ_NS       = 80;
    localparam int VPP_RAMP_NS   = 1000;
    localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC  = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC   = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAMP_CYC   = (VPP_RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W      = 8;

    // Host operations
    typedef enum logic [2:0] {
        OP_READ,
        OP_PROGRAM,
        OP_ERASE,
        OP_READ_ID,
        OP_ABORT
    } fcs_op_e;

    typedef struct packed {
        fcs_op_e             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } fcs_req_s;

    typedef struct packed {
        logic                ce_n;
        logic                we_n;
        logic                oe_n;
        logic                vpp_hi;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   dq_out;
        logic                dq_oe;
    } fcs_pins_s;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RAMP,
        ST_W_SETUP,
        ST_W_PULSE,
        ST_W_HOLD,
        ST_R_SETUP,
        ST_R_WAIT,
        ST_R_DONE,
        ST_DONE
    } fcs_state_e;

endpackage : fcs_pkg
